// >>> rtl/cfc_pkg.sv
// Constants for the CAN command, status and acceptance filter block
// Function
// [RULE_01] Select bits read back routing switch state
// [RULE_02] Select pair picks comparator pin or half-supply
// [RULE_03] Host writes wake mode with sleep request
// [RULE_04] Sleep needs request, idle bus, no interrupt
// [RULE_05] Wake on request low or activity; flag
// [RULE_06] Activity wake skips frame until bus free
// [RULE_07] Sleep bit reads actual sleep state
// [RULE_08] Host clears overrun with second buffer release
// [RULE_09] Host releases buffer; next one shows immediately
// [RULE_10] Host spaces release commands three cycles apart
// [RULE_11] Abort cancels pending request, not active frame
// [RULE_12] Host checks completion after release or interrupt
// [RULE_13] Writing request low never withdraws it
// [RULE_14] Reset request forces listed idle values
// [RULE_15] Some reset values only after external reset
// [RULE_16] Filter registers accessible only under reset request
// [RULE_17] Accepted frame stored into an empty buffer
// [RULE_18] No empty buffer sets data overrun
// [RULE_19] Complete frame sets full and receive flag
// [RULE_20] Own accepted transmit stored like received frame
// [RULE_21] Match code to top identifier, mask-ored, all ones
// [RULE_22] Mask high ignores bit, low compares it
// [RULE_23] Control bit 0 holds controller in reset
package cfc_pkg;
    localparam int        ADDR_W            = 5;
    localparam logic [4:0] ADDR_CONTROL     = 5'h00;
    localparam logic [4:0] ADDR_COMMAND     = 5'h01;
    localparam logic [4:0] ADDR_STATUS      = 5'h02;
    localparam logic [4:0] ADDR_IRQ_FLAGS   = 5'h03;
    localparam logic [4:0] ADDR_MATCH       = 5'h04;
    localparam logic [4:0] ADDR_IGNORE      = 5'h05;
    localparam logic [4:0] ADDR_RXBUF_BASE  = 5'h14;
    localparam int        RXBUF_BYTES       = 10;
    // Control bits
    localparam int CTL_RR  = 0;
    localparam int CTL_RIE = 1;
    localparam int CTL_TIE = 2;
    localparam int CTL_EIE = 3;
    localparam int CTL_OIE = 4;
    localparam int CTL_RA  = 5;
    localparam int CTL_TM  = 7;
    localparam logic [7:0] CTL_RESET = 8'h21;
    // Command bits
    localparam int CMD_TR   = 0;
    localparam int CMD_AT   = 1;
    localparam int CMD_RRB  = 2;
    localparam int CMD_COS  = 3;
    localparam int CMD_SLP  = 4;
    localparam int CMD_WUM  = 5;
    localparam int CMD_RX1_COMPARATOR_SELECT = 6;
    localparam int CMD_RX0_COMPARATOR_SELECT = 7;
    // Status bits
    localparam int ST_RBS = 0;
    localparam int ST_DO  = 1;
    localparam int ST_TBS = 2;
    localparam int ST_TCS = 3;
    localparam int ST_RS  = 4;
    localparam int ST_TS  = 5;
    localparam int ST_ES  = 6;
    localparam int ST_BS  = 7;
    // Interrupt flag bits
    localparam int IR_RI  = 0;
    localparam int IR_TI  = 1;
    localparam int IR_OI  = 3;
    localparam int IR_WUI = 4;
    localparam logic [4:0] IR_NONE    = 5'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [7:0] LOCKED_READ = 8'hFF;
    localparam logic [7:0] ALL_MATCH  = 8'hFF;
    typedef enum logic {CFC_AWAKE, CFC_ASLEEP} cfc_pwr_t;
    typedef enum logic [1:0] {CFC_RX_IDLE, CFC_RX_STORE} cfc_rx_t;
endpackage : cfc_pkg

// >>> rtl/cfc_can_ctrl.sv
// CAN command, status, receive buffer and acceptance filter logic
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module cfc_can_ctrl
    import cfc_pkg::*;
#(
    parameter int BUF_BYTES = RXBUF_BYTES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic              rx0_comparator_pin_i,
    input  wire logic              rx1_comparator_pin_i,
    output logic                   rx0_o,
    output logic                   rx1_o,
    output logic                   rx0_half_supply_o,
    output logic                   rx1_half_supply_o,
    input  wire logic              bus_activity_i,
    input  wire logic              bus_idle_i,
    input  wire logic              frame_start_i,
    input  wire logic [7:0]        frame_id_i,
    input  wire logic              frame_byte_valid_i,
    input  wire logic [7:0]        frame_byte_i,
    input  wire logic              frame_ok_i,
    input  wire logic              frame_err_i,
    input  wire logic              tx_start_i,
    input  wire logic              tx_done_i,
    input  wire logic              bus_off_i,
    input  wire logic              error_warning_i,
    output logic                   tx_request_o,
    output logic                   sleep_o,
    output logic                   reset_mode_o,
    output logic                   wakeup_mode_o
);
    localparam int IDX_W = $clog2(BUF_BYTES);

    function automatic logic filter_pass(input logic [7:0] id, input logic [7:0] code,
                                         input logic [7:0] mask);
        filter_pass = (((~(id ^ code)) | mask) == ALL_MATCH); // [RULE_21] [RULE_22]
    endfunction : filter_pass

    function automatic logic reg_write(input logic wr, input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] target);
        reg_write = wr && (a == target);
    endfunction : reg_write

    logic [7:0]       ctl_reg,      ctl_next;
    logic             rx0_sel_reg,  rx0_sel_next;
    logic             rx1_sel_reg,  rx1_sel_next;
    logic             rx0_mid_reg,  rx0_mid_next;
    logic             rx1_mid_reg,  rx1_mid_next;
    logic             wum_reg,      wum_next;
    logic             slp_req_reg,  slp_req_next;
    cfc_pwr_t         pwr_reg,      pwr_next;
    logic             blocked_reg,  blocked_next;
    logic             tr_reg,       tr_next;
    logic             txact_reg,    txact_next;
    logic             tcs_reg,      tcs_next;
    logic             tbs_reg,      tbs_next;
    logic             do_reg,       do_next;
    logic [4:0]       ir_reg,       ir_next;
    logic [7:0]       match_reg,    match_next;
    logic [7:0]       ignore_reg,   ignore_next;
    logic [1:0]       full_reg,     full_next;
    logic             head_reg,     head_next;
    cfc_rx_t          rx_reg,       rx_next;
    logic             sel_reg,      sel_next;
    logic [IDX_W-1:0] idx_reg,      idx_next;
    logic [7:0]       rdata_next;
    logic             bs_reg,       es_reg;
    logic             act_meta_reg, act_sync_reg;
    logic             c0_meta_reg,  c0_sync_reg;
    logic             c1_meta_reg,  c1_sync_reg;
    logic [7:0]       buf_mem [2][BUF_BYTES];
    logic             mem_we;
    logic [7:0]       status_val;
    logic             rr;
    logic             wr_ctl, wr_cmd;
    logic             free_idx;
    logic             has_free;
    logic [ADDR_W-1:0] buf_off;

    assign rr       = ctl_reg[CTL_RR]; // [RULE_23]
    assign wr_ctl   = reg_write(wr_i, addr_i, ADDR_CONTROL);
    assign wr_cmd   = reg_write(wr_i, addr_i, ADDR_COMMAND);
    assign free_idx = head_reg ^ full_reg[head_reg];
    assign has_free = !(full_reg[0] && full_reg[1]);
    assign buf_off  = addr_i - ADDR_RXBUF_BASE;
    assign mem_we   = (rx_reg == CFC_RX_STORE) && frame_byte_valid_i;

    always_comb begin
        status_val          = BYTE_ZERO;
        status_val[ST_BS]   = bs_reg;
        status_val[ST_ES]   = es_reg;
        status_val[ST_TS]   = txact_reg;
        status_val[ST_RS]   = (rx_reg == CFC_RX_STORE);
        status_val[ST_TCS]  = tcs_reg;
        status_val[ST_TBS]  = tbs_reg;
        status_val[ST_DO]   = do_reg;
        status_val[ST_RBS]  = full_reg[head_reg];
    end

    always_comb begin
        ctl_next     = ctl_reg;
        rx0_sel_next = rx0_sel_reg;
        rx1_sel_next = rx1_sel_reg;
        rx0_mid_next = rx0_mid_reg;
        rx1_mid_next = rx1_mid_reg;
        wum_next     = wum_reg;
        slp_req_next = slp_req_reg;
        pwr_next     = pwr_reg;
        blocked_next = blocked_reg;
        tr_next      = tr_reg;
        txact_next   = txact_reg;
        tcs_next     = tcs_reg;
        tbs_next     = tbs_reg;
        do_next      = do_reg;
        ir_next      = ir_reg;
        match_next   = match_reg;
        ignore_next  = ignore_reg;
        full_next    = full_reg;
        head_next    = head_reg;
        rx_next      = rx_reg;
        sel_next     = sel_reg;
        idx_next     = idx_reg;
        rdata_next   = BYTE_ZERO;
        // Interrupt flags clear on read; a new event in the same cycle survives
        if (rd_i && addr_i == ADDR_IRQ_FLAGS) begin
            ir_next = IR_NONE;
        end
        if (wr_ctl) begin
            ctl_next = wdata_i;
        end
        if (wr_cmd) begin
            if (wdata_i[CMD_RX0_COMPARATOR_SELECT] || wdata_i[CMD_RX1_COMPARATOR_SELECT]) begin // [RULE_02]
                rx0_sel_next = wdata_i[CMD_RX0_COMPARATOR_SELECT];
                rx1_sel_next = wdata_i[CMD_RX1_COMPARATOR_SELECT];
                rx0_mid_next = !wdata_i[CMD_RX0_COMPARATOR_SELECT];
                rx1_mid_next = !wdata_i[CMD_RX1_COMPARATOR_SELECT];
            end
            if (!rr) begin
                wum_next     = wdata_i[CMD_WUM]; // [RULE_03]
                slp_req_next = wdata_i[CMD_SLP];
                if (wdata_i[CMD_TR] && tbs_reg) begin // [RULE_13]
                    tr_next  = 1'b1;
                    tcs_next = 1'b0;
                    tbs_next = 1'b0;
                end
                if (wdata_i[CMD_AT] && tr_reg && !txact_reg) begin // [RULE_11]
                    tr_next  = 1'b0;
                    tbs_next = 1'b1;
                end
                if (wdata_i[CMD_COS]) begin // [RULE_08]
                    do_next = 1'b0;
                end
                if (wdata_i[CMD_RRB] && full_reg[head_reg]) begin // [RULE_09]
                    full_next[head_reg] = 1'b0;
                    head_next           = !head_reg;
                end
            end
        end
        if (rr) begin
            if (reg_write(wr_i, addr_i, ADDR_MATCH)) begin // [RULE_16]
                match_next = wdata_i;
            end
            if (reg_write(wr_i, addr_i, ADDR_IGNORE)) begin // [RULE_16]
                ignore_next = wdata_i;
            end
        end
        // Transmit handshake with the frame engine
        if (tx_start_i && tr_reg) begin
            txact_next = 1'b1;
        end
        if (tx_done_i && txact_reg) begin // [RULE_11]
            txact_next = 1'b0;
            tr_next    = 1'b0;
            tcs_next   = 1'b1;
            tbs_next   = 1'b1;
            if (ctl_reg[CTL_TIE]) begin
                ir_next[IR_TI] = 1'b1;
            end
        end
        // Sleep control
        unique case (pwr_reg)
            CFC_AWAKE: begin
                if (slp_req_next && bus_idle_i && !act_sync_reg && ir_reg == IR_NONE) begin
                    pwr_next = CFC_ASLEEP; // [RULE_04]
                end
            end
            CFC_ASLEEP: begin
                if (!slp_req_next || act_sync_reg) begin // [RULE_05]
                    pwr_next        = CFC_AWAKE;
                    slp_req_next    = 1'b0;
                    ir_next[IR_WUI] = 1'b1;
                    blocked_next    = act_sync_reg; // [RULE_06]
                end
            end
        endcase
        if (blocked_reg && bus_idle_i) begin // [RULE_06]
            blocked_next = 1'b0;
        end
        // Receive path; own transmitted frames arrive here the same way
        unique case (rx_reg)
            CFC_RX_IDLE: begin
                if (frame_start_i && !rr && pwr_reg == CFC_AWAKE && !blocked_reg
                    && filter_pass(frame_id_i, match_reg, ignore_reg)) begin // [RULE_20]
                    if (has_free) begin // [RULE_17]
                        rx_next  = CFC_RX_STORE;
                        sel_next = free_idx;
                        idx_next = '0;
                    end else begin // [RULE_18]
                        do_next = 1'b1;
                        if (ctl_reg[CTL_OIE]) begin
                            ir_next[IR_OI] = 1'b1;
                        end
                    end
                end
            end
            CFC_RX_STORE: begin
                if (frame_byte_valid_i && idx_reg != IDX_W'(BUF_BYTES - 1)) begin
                    idx_next = idx_reg + 1'b1; // [RULE_17]
                end
                if (frame_ok_i) begin // [RULE_19]
                    rx_next            = CFC_RX_IDLE;
                    full_next[sel_reg] = 1'b1;
                    if (ctl_reg[CTL_RIE]) begin
                        ir_next[IR_RI] = 1'b1;
                    end
                end else if (frame_err_i) begin
                    rx_next = CFC_RX_IDLE;
                end
            end
            default: begin
                rx_next = CFC_RX_IDLE;
            end
        endcase
        // Reset request overrides every bit that it governs
        if (rr) begin // [RULE_14]
            ctl_next[CTL_TM] = 1'b0;
            slp_req_next     = 1'b0;
            pwr_next         = CFC_AWAKE;
            tr_next          = 1'b0;
            txact_next       = 1'b0;
            tcs_next         = 1'b1;
            tbs_next         = 1'b1;
            do_next          = 1'b0;
            ir_next[IR_OI]   = 1'b0;
            ir_next[IR_TI]   = 1'b0;
            ir_next[IR_RI]   = 1'b0;
            full_next        = 2'b00;
            head_next        = 1'b0;
            rx_next          = CFC_RX_IDLE;
        end
        // Read data appear one cycle after the strobe and only then
        if (rd_i) begin
            if (addr_i == ADDR_CONTROL) begin
                rdata_next = ctl_reg;
            end else if (addr_i == ADDR_COMMAND) begin
                rdata_next[CMD_RX0_COMPARATOR_SELECT] = rx0_sel_reg; // [RULE_01]
                rdata_next[CMD_RX1_COMPARATOR_SELECT] = rx1_sel_reg; // [RULE_01]
                rdata_next[CMD_WUM]  = wum_reg;
                rdata_next[CMD_SLP]  = (pwr_reg == CFC_ASLEEP); // [RULE_07]
                rdata_next[CMD_COS]  = rr; // [RULE_14]
                rdata_next[CMD_RRB]  = rr; // [RULE_14]
                rdata_next[CMD_TR]   = tr_reg;
            end else if (addr_i == ADDR_STATUS) begin
                rdata_next = status_val;
            end else if (addr_i == ADDR_IRQ_FLAGS) begin
                rdata_next = {3'b000, ir_reg};
            end else if (addr_i == ADDR_MATCH) begin
                rdata_next = rr ? match_reg : LOCKED_READ; // [RULE_16]
            end else if (addr_i == ADDR_IGNORE) begin
                rdata_next = rr ? ignore_reg : LOCKED_READ; // [RULE_16]
            end else if (addr_i >= ADDR_RXBUF_BASE
                         && buf_off < ADDR_W'(BUF_BYTES)) begin
                rdata_next = buf_mem[head_reg][buf_off[IDX_W-1:0]]; // [RULE_09]
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_reg      <= CTL_RESET; // [RULE_15]
            rx0_sel_reg  <= 1'b1; // [RULE_15]
            rx1_sel_reg  <= 1'b1; // [RULE_15]
            rx0_mid_reg  <= 1'b0;
            rx1_mid_reg  <= 1'b0;
            wum_reg      <= 1'b0;
            slp_req_reg  <= 1'b0;
            pwr_reg      <= CFC_AWAKE;
            blocked_reg  <= 1'b0;
            tr_reg       <= 1'b0;
            txact_reg    <= 1'b0;
            tcs_reg      <= 1'b1;
            tbs_reg      <= 1'b1;
            do_reg       <= 1'b0;
            ir_reg       <= IR_NONE;
            match_reg    <= BYTE_ZERO;
            ignore_reg   <= LOCKED_READ;
            full_reg     <= 2'b00;
            head_reg     <= 1'b0;
            rx_reg       <= CFC_RX_IDLE;
            sel_reg      <= 1'b0;
            idx_reg      <= '0;
            rdata_o      <= BYTE_ZERO;
            bs_reg       <= 1'b0; // [RULE_15]
            es_reg       <= 1'b0; // [RULE_15]
            act_meta_reg <= 1'b0;
            act_sync_reg <= 1'b0;
            c0_meta_reg  <= 1'b0;
            c0_sync_reg  <= 1'b0;
            c1_meta_reg  <= 1'b0;
            c1_sync_reg  <= 1'b0;
            rx0_o        <= 1'b0;
            rx1_o        <= 1'b0;
            rx0_half_supply_o <= 1'b0;
            rx1_half_supply_o <= 1'b0;
            tx_request_o <= 1'b0;
            sleep_o      <= 1'b0;
            reset_mode_o <= 1'b1;
            wakeup_mode_o <= 1'b0;
        end else begin
            ctl_reg      <= ctl_next;
            rx0_sel_reg  <= rx0_sel_next;
            rx1_sel_reg  <= rx1_sel_next;
            rx0_mid_reg  <= rx0_mid_next;
            rx1_mid_reg  <= rx1_mid_next;
            wum_reg      <= wum_next;
            slp_req_reg  <= slp_req_next;
            pwr_reg      <= pwr_next;
            blocked_reg  <= blocked_next;
            tr_reg       <= tr_next;
            txact_reg    <= txact_next;
            tcs_reg      <= tcs_next;
            tbs_reg      <= tbs_next;
            do_reg       <= do_next;
            ir_reg       <= ir_next;
            match_reg    <= match_next;
            ignore_reg   <= ignore_next;
            full_reg     <= full_next;
            head_reg     <= head_next;
            rx_reg       <= rx_next;
            sel_reg      <= sel_next;
            idx_reg      <= idx_next;
            rdata_o      <= rdata_next;
            // Error flags track the engine; only the external reset forces them
            bs_reg       <= bus_off_i; // [RULE_15]
            es_reg       <= error_warning_i; // [RULE_15]
            act_meta_reg <= bus_activity_i;
            act_sync_reg <= act_meta_reg;
            c0_meta_reg  <= rx0_comparator_pin_i;
            c0_sync_reg  <= c0_meta_reg;
            c1_meta_reg  <= rx1_comparator_pin_i;
            c1_sync_reg  <= c1_meta_reg;
            rx0_o        <= rx0_mid_reg ? 1'b0 : c0_sync_reg; // [RULE_02]
            rx1_o        <= rx1_mid_reg ? 1'b0 : c1_sync_reg; // [RULE_02]
            rx0_half_supply_o <= rx0_mid_reg;
            rx1_half_supply_o <= rx1_mid_reg;
            tx_request_o <= tr_next;
            sleep_o      <= (pwr_next == CFC_ASLEEP);
            reset_mode_o <= ctl_next[CTL_RR];
            wakeup_mode_o <= wum_next;
        end
    end

    // Buffer storage has no reset; the buffer window reads the head buffer whether or not it is marked full
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            buf_mem[sel_reg][idx_reg] <= frame_byte_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_accept_start;
        rx_reg == CFC_RX_IDLE && frame_start_i && !rr && pwr_reg == CFC_AWAKE
            && !blocked_reg && filter_pass(frame_id_i, match_reg, ignore_reg);
    endsequence
    sequence s_asleep_woken;
        pwr_reg == CFC_ASLEEP && act_sync_reg;
    endsequence

    reset_forces_idle_a: assert property ( // [RULE_14]
        rr && $past(rr) |-> !tr_reg && !do_reg && full_reg == 2'b00 && tbs_reg && tcs_reg)
        else $error("reset request did not force idle state");
    filter_locked_a: assert property ( // [RULE_16]
        wr_i && addr_i == ADDR_MATCH && !rr |=> $stable(match_reg))
        else $error("match value changed outside reset request");
    store_start_a: assert property ( // [RULE_17]
        s_accept_start ##0 has_free |=> rx_reg == CFC_RX_STORE && sel_reg == $past(free_idx))
        else $error("accepted frame not stored into free buffer");
    overrun_set_a: assert property ( // [RULE_18]
        s_accept_start ##0 !has_free |=> do_reg)
        else $error("overrun not flagged with both buffers full");
    frame_done_a: assert property ( // [RULE_19]
        rx_reg == CFC_RX_STORE && frame_ok_i && !rr |=> full_reg[$past(sel_reg)]
            && (ir_reg[IR_RI] == $past(ctl_reg[CTL_RIE]) || $past(ir_reg[IR_RI])))
        else $error("complete frame did not mark buffer full");
    request_hold_a: assert property ( // [RULE_13]
        tr_reg && wr_cmd && !wdata_i[CMD_TR] && !wdata_i[CMD_AT] && !tx_done_i && !rr |=> tr_reg)
        else $error("transmit request withdrawn by writing it low");
    abort_pending_a: assert property ( // [RULE_11]
        wr_cmd && wdata_i[CMD_AT] && tr_reg && !txact_reg && !rr |=> !tr_reg && !tx_request_o)
        else $error("abort did not cancel pending request");
    wake_flag_a: assert property ( // [RULE_05]
        s_asleep_woken |=> pwr_reg == CFC_AWAKE && ir_reg[IR_WUI] && blocked_reg)
        else $error("activity wake did not flag and block reception");
    sleep_entry_a: assert property ( // [RULE_04]
        $rose(pwr_reg == CFC_ASLEEP) |-> $past(ir_reg == IR_NONE && bus_idle_i))
        else $error("sleep entered with interrupt pending or busy bus");
    sleep_read_a: assert property ( // [RULE_07]
        rd_i && addr_i == ADDR_COMMAND |=> rdata_o[CMD_SLP] == $past(pwr_reg == CFC_ASLEEP))
        else $error("sleep bit read does not show sleep state");
    accept_calc_a: assert property ( // [RULE_21]
        !status_val[ST_RS] && frame_start_i && !(&(~(frame_id_i ^ match_reg) | ignore_reg))
            |=> !status_val[ST_RS])
        else $error("frame accepted against filter");
endmodule : cfc_can_ctrl

// >>> verif/cfc_bus_model.sv
// Far-side bus partner: frame source and transmit engine
`timescale 1ns/1ps
module cfc_bus_model (
    input  wire logic       clk_i,
    input  wire logic       send_i,
    input  wire logic [7:0] id_i,
    input  wire logic       tx_request_i,
    input  wire logic       tx_hold_i,
    output logic            frame_start_o,
    output logic [7:0]      frame_id_o,
    output logic            byte_valid_o,
    output logic [7:0]      byte_o,
    output logic            frame_ok_o,
    output logic            tx_start_o,
    output logic            tx_done_o
);
    // Idle data lines carry the inverse so a stale value never looks valid
    initial begin
        {frame_start_o, byte_valid_o, frame_ok_o, tx_start_o, tx_done_o} = 5'h00;
        frame_id_o = 8'h00;
        byte_o = 8'h00;
        forever begin
            @(posedge clk_i);
            if (send_i) begin
                frame_start_o <= 1'b1;
                frame_id_o <= id_i;
                @(posedge clk_i);
                frame_start_o <= 1'b0;
                frame_id_o <= ~id_i;
                for (int n = 0; n < 2; n++) begin
                    @(posedge clk_i);
                    byte_valid_o <= 1'b1;
                    byte_o <= id_i + 8'(n);
                end
                @(posedge clk_i);
                byte_valid_o <= 1'b0;
                byte_o <= ~id_i;
                frame_ok_o <= 1'b1;
                @(posedge clk_i);
                frame_ok_o <= 1'b0;
            end else if (tx_request_i && !tx_hold_i) begin
                tx_start_o <= 1'b1;
                @(posedge clk_i);
                tx_start_o <= 1'b0;
                repeat (4) @(posedge clk_i);
                tx_done_o <= 1'b1;
                @(posedge clk_i);
                tx_done_o <= 1'b0;
                wait (!tx_request_i);
            end
        end
    end
endmodule : cfc_bus_model

// >>> verif/cfc_can_ctrl_tb.sv
// Self-checking bench for the CAN command and acceptance filter block
`timescale 1ns/1ps
module cfc_can_ctrl_tb;
    import cfc_pkg::*;
    logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, send = 0, hold = 1, act = 0, p0 = 0, p1 = 0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00, id = 8'h00, rdata_o, fid, fb, d, m, k, v;
    logic fs, fv, fok, ts, td, txr, ra, rb, h0, h1, sl, rm, wm;
    logic [31:0] seed = 32'h93FA;
    int n_mismatch = 0, compares = 0;
    cfc_can_ctrl i_cfc_can_ctrl (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .rx0_comparator_pin_i(p0), .rx1_comparator_pin_i(p1), .rx0_o(ra), .rx1_o(rb),
        .rx0_half_supply_o(h0), .rx1_half_supply_o(h1), .bus_activity_i(act), .bus_idle_i(1'b1),
        .frame_start_i(fs), .frame_id_i(fid), .frame_byte_valid_i(fv), .frame_byte_i(fb),
        .frame_ok_i(fok), .frame_err_i(1'b0), .tx_start_i(ts), .tx_done_i(td), .bus_off_i(1'b0),
        .error_warning_i(1'b0), .tx_request_o(txr),
        .sleep_o(sl), .reset_mode_o(rm), .wakeup_mode_o(wm));
    cfc_bus_model i_cfc_bus_model (.clk_i, .send_i(send), .id_i(id), .tx_request_i(txr),
        .tx_hold_i(hold), .frame_start_o(fs), .frame_id_o(fid), .byte_valid_o(fv), .byte_o(fb),
        .frame_ok_o(fok), .tx_start_o(ts), .tx_done_o(td));
    initial forever #2 clk_i = ~clk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic pass(input logic [7:0] i, c, x);
        return &(~(i ^ c) | x);
    endfunction : pass
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] x);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= x;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Read data stand one cycle only
    task automatic rdc(input string s, input logic [4:0] a, input logic [7:0] msk, e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(s, e, rdata_o & msk);
    endtask : rdc
    task automatic frame(input logic [7:0] x);
        @(posedge clk_i);
        send <= 1'b1;
        id <= x;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask : frame
    task automatic complete_run;
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdc("control", ADDR_CONTROL, 8'hFF, CTL_RESET);
        rdc("status", ADDR_STATUS, 8'hFF, 8'h0C);
        rdc("command", ADDR_COMMAND, 8'hFD, 8'hCC);
        seed = xs(seed);
        m = seed[7:0];
        k = seed[15:8] & 8'h0F;
        p0 <= seed[16];
        p1 <= seed[17];
        wr(ADDR_MATCH, m);
        wr(ADDR_IGNORE, k);
        rdc("match", ADDR_MATCH, 8'hFF, m);
        rdc("ignore", ADDR_IGNORE, 8'hFF, k);
        wr(ADDR_CONTROL, 8'h02);
        wr(ADDR_MATCH, ~m);
        rdc("locked", ADDR_MATCH, 8'hFF, LOCKED_READ);
        // Odd passes are built to hit the filter, even ones mostly miss it
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            v = i[0] ? m ^ (seed[7:0] & k) : seed[7:0];
            frame(v);
            rdc("full", ADDR_STATUS, 8'h01, {7'h00, pass(v, m, k)});
            if (pass(v, m, k)) begin
                rdc("rx flag", ADDR_IRQ_FLAGS, 8'h01, 8'h01);
                rdc("rx byte", ADDR_RXBUF_BASE, 8'hFF, v);
                wr(ADDR_COMMAND, 8'h04);
            end
        end
        repeat (3) frame(m);
        rdc("overrun", ADDR_STATUS, 8'h03, 8'h03);
        wr(ADDR_COMMAND, 8'h04);
        repeat (3) @(posedge clk_i);
        wr(ADDR_COMMAND, 8'h0C);
        rdc("cleared", ADDR_STATUS, 8'h03, 8'h00);
        wr(ADDR_COMMAND, 8'h01);
        wr(ADDR_COMMAND, 8'h00);
        rdc("pending", ADDR_COMMAND, 8'h01, 8'h01);
        wr(ADDR_COMMAND, 8'h02);
        rdc("aborted", ADDR_STATUS, 8'h0C, 8'h04);
        hold <= 1'b0;
        wr(ADDR_COMMAND, 8'h01);
        repeat (12) @(posedge clk_i);
        rdc("sent", ADDR_STATUS, 8'h2C, 8'h0C);
        rdc("flags", ADDR_IRQ_FLAGS, 8'h1F, 8'h01);
        wr(ADDR_COMMAND, 8'h30);
        repeat (2) @(posedge clk_i);
        rdc("asleep", ADDR_COMMAND, 8'h10, 8'h10);
        chk("pins", 8'h05, {5'h00, sl, rm, wm});
        act <= 1'b1;
        repeat (4) @(posedge clk_i);
        act <= 1'b0;
        rdc("awake", ADDR_COMMAND, 8'h10, 8'h00);
        rdc("wake flag", ADDR_IRQ_FLAGS, 8'h10, 8'h10);
        wr(ADDR_CONTROL, 8'h01);
        rdc("rr status", ADDR_STATUS, 8'hFF, 8'h0C);
        wr(ADDR_COMMAND, 8'h80);
        rdc("select", ADDR_COMMAND, 8'hC0, 8'h80);
        chk("half", 8'h01, {6'h00, h0, h1});
        wr(ADDR_COMMAND, 8'h00);
        rdc("kept", ADDR_COMMAND, 8'hC0, 8'h80);
        wr(ADDR_COMMAND, 8'hC0);
        repeat (4) @(posedge clk_i);
        chk("route", {6'h00, p0, p1}, {6'h00, ra, rb});
        complete_run();
    end
endmodule : cfc_can_ctrl_tb
